// [core/usb_host_legacy_handoff_regs.v]
// configuration registers for port wake policy and legacy ownership handoff
// Functional notes
// - seven-bit read/write per-port wake mask
// - bit 16 read/write firmware ownership flag
// - wake mask stored and copied to the port_wake_policy pins
// - wake register resets to 7fh
// - bit 24 os ownership request flag
// - bits 15:8 read 00h
// - bits 7:0 read 01h
// - bit 31 set on bar write
// - bit 30 set on command write
// - bit 29 set on os flag change
// - bits 31:29 write-one-to-clear
// - bit 21 mirrors async advance status
// - bit 20 mirrors host system error
// - bits 19:17 mirror rollover, port, error
`timescale 1ns/1ps
`default_nettype none
`include "legacy_handoff_regs.vh"
module usb_host_legacy_handoff_regs (
  input  wire        clk,
  input  wire        rstn,
  input  wire        ce,
  input  wire        cfg_rd,
  input  wire        cfg_wr,
  input  wire [7:0]  cfg_addr,
  input  wire [3:0]  cfg_be,
  input  wire [31:0] cfg_wdata,
  input  wire        bar_write,
  input  wire        command_write,
  input  wire        async_advance_sts,
  input  wire        host_error_sts,
  input  wire        frame_rollover_sts,
  input  wire        port_change_sts,
  input  wire        transfer_error_interrupt,
  output reg  [31:0] cfg_rdata,
  output reg         cfg_rvalid,
  output reg  [6:0]  port_wake_policy,
  output reg         os_owned,
  output reg         fw_owned
);
  // stored state
  reg  [15:0] wake_reg;
  reg         os_reg;
  reg         fw_reg;
  reg  [2:0]  evt_reg;
  reg  [4:0]  shadow_reg;
  reg  [31:0] rd_mux;

  // address decode and qualified strobes
  wire        hit_wake;
  wire        hit_cap;
  wire        hit_cs;
  wire        wake_we;
  wire        cap_we;
  wire        rd_take;

  // read images and merged write values
  wire [31:0] cap_img;
  wire [31:0] cs_img;
  wire [31:0] wake_img;
  wire [31:0] cap_new;
  wire [31:0] wake_new;
  wire [31:0] wr_lanes;

  // next values and event sources
  wire        os_next;
  wire [2:0]  evt_set;
  wire [2:0]  evt_clr;
  wire [4:0]  shadow_src;

  // dword decode; wake register sits in the upper half of dword 60h
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a[7:2] == ofs[7:2]);
    end
  endfunction

  assign hit_wake = hit(cfg_addr, `PORT_WAKE_POLICY_OFS);
  assign hit_cap  = hit(cfg_addr, `LEGACY_CAP_OFS);
  assign hit_cs   = hit(cfg_addr, `LEGACY_CS_OFS);

  // wake register is the upper half of dword 60h; the lower half reads zero here
  assign wake_img = {wake_reg, 16'h0000};

  // capability image; reserved fields tie to zero
  assign cap_img  = {7'h00, os_reg,
                     7'h00, fw_reg,
                     `LEGACY_CAP_NEXT,
                     `LEGACY_CAP_ID};

  // control/status image: events on top, shadows in 21:17, the rest zero
  assign cs_img   = {evt_reg, 7'h00, shadow_reg, 17'h00000};

  // capability merge; its lane mask also qualifies the status clears
  cfg_byte_merge u_cap_merge (
    .old_val (cap_img),
    .wr_data (cfg_wdata),
    .byte_en (cfg_be),
    .new_val (cap_new),
    .wr_bits (wr_lanes)
  );

  // wake merge; only bits 22:16 of lane 2 ever reach the register
  cfg_byte_merge u_wake_merge (
    .old_val (wake_img),
    .wr_data (cfg_wdata),
    .byte_en (cfg_be),
    .new_val (wake_new),
    .wr_bits ()
  );

  assign os_next = (cfg_wr && hit_cap) ? cap_new[`CAP_OS_OWNED_BIT] : os_reg;

  // event sources; a set in the clearing cycle wins
  assign evt_set = {bar_write, command_write, os_next != os_reg};
  assign evt_clr = (cfg_wr && hit_cs) ? (cfg_wdata[31:29] & wr_lanes[31:29]) : 3'h0;

  // write and read strobes, qualified by the clock enable
  assign wake_we = ce && cfg_wr && hit_wake;
  assign cap_we  = ce && cfg_wr && hit_cap;
  assign rd_take = ce && cfg_rd;

  // status sources in shadow order, bit 21 down to bit 17
  assign shadow_src = {async_advance_sts, host_error_sts, frame_rollover_sts,
                       port_change_sts, transfer_error_interrupt};

  // event flag update; losing an event costs more than a repeated smi
  function [2:0] w1c_update;
    input [2:0] cur;
    input [2:0] evt_in;
    input [2:0] clr;
    begin
      w1c_update = evt_in | (cur & ~clr);
    end
  endfunction

  // wake policy mask, suspend-well reset only
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wake_reg <= `PORT_WAKE_POLICY_RST;
    end else if (wake_we) begin
      // stored; read back through the wake image and by the registered port_wake_policy pin copy
      wake_reg <= wake_new[31:16] & `PORT_WAKE_POLICY_MASK;
    end
  end

  // ownership semaphores
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      os_reg <= 1'b0;
      fw_reg <= 1'b0;
    end else if (ce) begin
      os_reg <= os_next;
      // firmware claims and releases via bit 16
      if (cap_we) begin
        fw_reg <= cap_new[`CAP_FW_OWNED_BIT];
      end
    end
  end

  // smi event flags, write-one-to-clear
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      evt_reg <= 3'h0;
    end else if (ce) begin
      evt_reg <= w1c_update(evt_reg, evt_set, evt_clr);
    end
  end

  // shadows lag their source one edge; cleared only at the source
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shadow_reg <= 5'h00;
    end else if (ce) begin
      shadow_reg <= shadow_src;
    end
  end

  // read select; unmapped dwords read zero
  always @* begin
    rd_mux = 32'h00000000;
    if (hit_wake) begin
      rd_mux = wake_img;
    end else if (hit_cap) begin
      rd_mux = cap_img;
    end else if (hit_cs) begin
      rd_mux = cs_img;
    end
  end

  // read port; rvalid pulses one cycle, rdata holds until the next read
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_rdata  <= 32'h00000000;
      cfg_rvalid <= 1'b0;
    end else if (ce) begin
      cfg_rvalid <= cfg_rd;
      if (rd_take) begin
        cfg_rdata <= rd_mux;
      end
    end
  end

  // pin copies, registered so no decode glitch reaches the outputs
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      port_wake_policy <= `PORT_WAKE_PIN_RST;
      os_owned         <= 1'b0;
      fw_owned         <= 1'b0;
    end else if (ce) begin
      port_wake_policy <= wake_reg[6:0];
      // os holds the controller when its flag is set and firmware released
      os_owned <= os_reg & ~fw_reg;
      fw_owned <= fw_reg;
    end
  end
endmodule
`default_nettype wire

// [core/legacy_handoff_regs.vh]
// offsets, field positions and reset values of the legacy handoff registers
`ifndef LEGACY_HANDOFF_REGS_VH
`define LEGACY_HANDOFF_REGS_VH
`define PORT_WAKE_POLICY_OFS      8'h62
`define LEGACY_CAP_OFS            8'h68
`define LEGACY_CS_OFS             8'h6c
`define PORT_WAKE_POLICY_RST      16'h007f
`define PORT_WAKE_POLICY_MASK     16'h007f
`define PORT_WAKE_PIN_RST         7'h7f
`define LEGACY_CAP_ID             8'h01
`define LEGACY_CAP_NEXT           8'h00
`define CAP_OS_OWNED_BIT          24
`define CAP_FW_OWNED_BIT          16
`define CS_BAR_WRITE_BIT          31
`define CS_CMD_WRITE_BIT          30
`define CS_OWN_CHANGE_BIT         29
`define CS_ASYNC_ADV_BIT          21
`define CS_HOST_ERR_BIT           20
`define CS_FRAME_ROLL_BIT         19
`define CS_PORT_CHANGE_BIT        18
`define CS_XFER_ERR_BIT           17
`endif

// [core/cfg_byte_merge.v]
// byte-enable merge of a config write into a 32-bit register image
`timescale 1ns/1ps
`default_nettype none
module cfg_byte_merge (
  input  wire [31:0] old_val,
  input  wire [31:0] wr_data,
  input  wire [3:0]  byte_en,
  output wire [31:0] new_val,
  output wire [31:0] wr_bits
);
  // per-lane select; wr_bits marks lanes actually written
  assign wr_bits = {{8{byte_en[3]}}, {8{byte_en[2]}}, {8{byte_en[1]}}, {8{byte_en[0]}}};
  assign new_val = (wr_data & wr_bits) | (old_val & ~wr_bits);
endmodule
`default_nettype wire

// [tb/lh_monitor.sv]
// checker on the legacy handoff register ports
`timescale 1ns/1ps
`default_nettype none
module lh_monitor (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        ce,
  input wire logic        cfg_rd,
  input wire logic [7:0]  cfg_addr,
  input wire logic [31:0] cfg_rdata,
  input wire logic        cfg_rvalid,
  input wire logic [6:0]  port_wake_policy,
  input wire logic        os_owned,
  input wire logic        fw_owned,
  input wire logic        host_error_sts
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // a read taken at this edge
  sequence rd(a); ce && cfg_rd && cfg_addr == a; endsequence
  a_read_valid: assert property (ce && cfg_rd |=> cfg_rvalid) else $error("no read valid");
  a_cap_fixed: assert property (rd(8'h68) |=>
    cfg_rdata[15:0] == 16'h0001 && cfg_rdata[31:25] == 0 && cfg_rdata[23:17] == 0) else $error("cap bits");
  a_cap_flags: assert property (rd(8'h68) |=>
    cfg_rdata[16] == fw_owned && os_owned == (cfg_rdata[24] && !cfg_rdata[16])) else $error("own flags");
  a_wake_read: assert property (rd(8'h60) |=>
    cfg_rdata[31:16] == {9'h0, port_wake_policy}) else $error("wake read");
  a_cs_reserved: assert property (rd(8'h6c) |=>
    cfg_rdata[28:22] == 0 && cfg_rdata[16:0] == 0) else $error("cs reserved");
  // shadow lags its source by one edge
  a_err_shadow: assert property (rd(8'h6c) ##0 $stable(host_error_sts) |=>
    cfg_rdata[20] == $past(host_error_sts)) else $error("error shadow");
  a_wake_reset: assert property ($rose(rstn) |-> port_wake_policy == 7'h7f) else $error("wake reset");
  // enable low holds every output where it stood
  a_ce_freeze: assert property (!ce |=> $stable(cfg_rvalid) && $stable(cfg_rdata) && $stable(port_wake_policy)
    && $stable(os_owned) && $stable(fw_owned)) else $error("ce freeze");
endmodule
`default_nettype wire

// [tb/cfg_host_model.sv]
// host bridge model issuing configuration cycles
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model (
  input  wire logic        clk,
  output logic        cfg_rd,
  output logic        cfg_wr,
  output logic [7:0]  cfg_addr,
  output logic [3:0]  cfg_be,
  output logic [31:0] cfg_wdata
);
  initial {cfg_rd, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {10'h0ff, 4'hf, 32'h0};
  // one-cycle request; lines scrambled after release so stale data never passes
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) #10;
    {cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = {w, !w, a, d};
    @(posedge clk) #10;
    {cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = {2'b00, ~a, ~d};
  endtask
  // write with a chosen lane mask; lanes fall back to all-on afterwards
  task acc_be(input logic [3:0] b, input logic [7:0] a, input logic [31:0] d);
    cfg_be = b;
    acc(1'b1, a, d);
    cfg_be = 4'hf;
  endtask
endmodule
`default_nettype wire

// [tb/usb_host_legacy_handoff_regs_tb_top.sv]
// self-checking bench for the legacy handoff registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin err_count++; $display("wrong value at %0t: %h", $time, a); end end
module usb_host_legacy_handoff_regs_tb_top;
  logic clk = 0, rstn = 0, ce = 1, bar_write = 0, command_write = 0, cfg_rd, cfg_wr, cfg_rvalid, os_owned, fw_owned;
  logic async_advance_sts = 0, host_error_sts = 0, frame_rollover_sts = 0, port_change_sts = 0;
  logic transfer_error_interrupt = 0;
  logic [7:0]  cfg_addr;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata;
  logic [6:0]  port_wake_policy;
  int          err_count = 0, checks_done = 0;
  // rows: address, written value, value read back
  logic [7:0]  ra [4] = '{8'h60, 8'h68, 8'h70, 8'h6c};
  logic [31:0] rw [4] = '{32'h0055ffff, 32'hffffffff, 32'hffffffff, 32'hffffffff};
  logic [31:0] re [4] = '{32'h00550000, 32'h01010001, 32'h0, 32'h0};
  always #50 clk = ~clk;
  cfg_host_model host (
    .clk       (clk),
    .cfg_rd    (cfg_rd),
    .cfg_wr    (cfg_wr),
    .cfg_addr  (cfg_addr),
    .cfg_be    (cfg_be),
    .cfg_wdata (cfg_wdata)
  );
  usb_host_legacy_handoff_regs uut (
    .clk                      (clk),
    .rstn                     (rstn),
    .ce                       (ce),
    .cfg_rd                   (cfg_rd),
    .cfg_wr                   (cfg_wr),
    .cfg_addr                 (cfg_addr),
    .cfg_be                   (cfg_be),
    .cfg_wdata                (cfg_wdata),
    .bar_write                (bar_write),
    .command_write            (command_write),
    .async_advance_sts        (async_advance_sts),
    .host_error_sts           (host_error_sts),
    .frame_rollover_sts       (frame_rollover_sts),
    .port_change_sts          (port_change_sts),
    .transfer_error_interrupt (transfer_error_interrupt),
    .cfg_rdata                (cfg_rdata),
    .cfg_rvalid               (cfg_rvalid),
    .port_wake_policy         (port_wake_policy),
    .os_owned                 (os_owned),
    .fw_owned                 (fw_owned)
  );
  task close_out;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #1000000 err_count++;
    close_out;
  end
  initial begin
    repeat (16) @(posedge clk);
    #10 rstn = 1;
    `CHK({port_wake_policy, os_owned, fw_owned, cfg_rvalid}, {7'h7f, 3'h0})
    foreach (ra[i]) begin
      host.acc(1, ra[i], rw[i]);
      host.acc(0, ra[i], 0);
      `CHK(cfg_rdata, re[i])
    end
    // both event pulses, then the os flag falls
    @(posedge clk) #10 bar_write = 1;
    @(posedge clk) #10 {bar_write, command_write} = 2'b01;
    @(posedge clk) #10 command_write = 0;
    host.acc(1, 8'h68, 32'h0);
    host.acc(0, 8'h6c, 0);
    `CHK(cfg_rdata, 32'he0000000)
    host.acc(1, 8'h6c, 32'h40000000);
    host.acc(0, 8'h6c, 0);
    `CHK(cfg_rdata, 32'ha0000000)
    {async_advance_sts, host_error_sts, frame_rollover_sts, port_change_sts, transfer_error_interrupt} = 5'h1f;
    host.acc(1, 8'h6c, 32'hffffffff);
    host.acc(0, 8'h6c, 0);
    `CHK(cfg_rdata, 32'h003e0000)
    // sources cleared at host status; the shadows must follow
    {async_advance_sts, host_error_sts, frame_rollover_sts, port_change_sts, transfer_error_interrupt} = 5'h00;
    // handoff: firmware claims, os asks, firmware lets go
    host.acc(1, 8'h68, 32'h00010000);
    host.acc(1, 8'h68, 32'h01010000);
    @(posedge clk) #10;
    `CHK({os_owned, fw_owned}, 2'b01)
    host.acc(1, 8'h68, 32'h01000000);
    @(posedge clk) #10;
    `CHK({os_owned, fw_owned}, 2'b10)
    // lane 3 left out, so the rising-edge event must survive
    host.acc_be(4'h7, 8'h6c, 32'hffffffff);
    host.acc(0, 8'h6c, 0);
    `CHK(cfg_rdata, 32'h20000000)
    ce = 0;
    host.acc(1, 8'h60, 32'h0);
    ce = 1;
    host.acc(0, 8'h60, 0);
    `CHK(cfg_rdata, 32'h00550000)
    `CHK(port_wake_policy, 7'h55)
    rstn = 0;
    #200 rstn = 1;
    host.acc(0, 8'h60, 0);
    `CHK(cfg_rdata, 32'h007f0000)
    `CHK(port_wake_policy, 7'h7f)
    close_out;
  end
endmodule
bind usb_host_legacy_handoff_regs lh_monitor mon (
  .clk              (clk),
  .rstn             (rstn),
  .ce               (ce),
  .cfg_rd           (cfg_rd),
  .cfg_addr         (cfg_addr),
  .cfg_rdata        (cfg_rdata),
  .cfg_rvalid       (cfg_rvalid),
  .port_wake_policy (port_wake_policy),
  .os_owned         (os_owned),
  .fw_owned         (fw_owned),
  .host_error_sts   (host_error_sts)
);
`default_nettype wire
